//--- design/msr_regs.sv
// Status and field-sample register bank of the three-axis magnetometer.
`timescale 1ns/10ps
`default_nettype none

module msr_regs #(
	parameter logic [7:0] DEVICE_CODE = 8'h5a,   // Arbitrary value.
	parameter logic [7:0] COMPANY_CODE = 8'ha5,  // Arbitrary value.
	parameter logic [15:0] RESERVED_WORD = 16'h0000
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Byte read port from the serial interface
	input wire logic acc_start,
	input wire logic [7:0] acc_addr,
	input wire logic acc_rd,
	output logic [7:0] rd_data,
	output logic rd_valid,
	// Settings held outside this bank
	input wire logic [3:0] op_mode,
	input wire logic range_select,
	input wire msr_pkg::msr_thr_s [2:0] thr,
	// Measurement engine
	input wire msr_pkg::msr_meas_s meas,
	// Status to event logic
	output logic data_ready_flag
);
	import msr_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers.

	function automatic logic is_cont(input logic [3:0] m);
		is_cont = (m != MODE_POWER_DOWN) && !m[0];
	endfunction

	function automatic logic is_active(input logic [3:0] m);
		is_active = (m == MODE_SINGLE) || is_cont(m);
	endfunction

	// Hysteresis: operating point sets, returning point clears, otherwise hold.
	function automatic logic sw_next(input logic cur, input logic signed [15:0] s,
		input logic signed [15:0] op, input logic signed [15:0] rp);
		if (s >= op) begin
			sw_next = 1'b1;
		end else if (s <= rp) begin
			sw_next = 1'b0;
		end else begin
			sw_next = cur;
		end
	endfunction

	function automatic logic signed [15:0] clamp_wide(input logic signed [15:0] s);
		if (s > WIDE_LIMIT) begin
			clamp_wide = WIDE_LIMIT;
		end else if (s < -WIDE_LIMIT) begin
			clamp_wide = -WIDE_LIMIT;
		end else begin
			clamp_wide = s;
		end
	endfunction

	// Picks the n-th present axis, in the order Z, Y, X, from a selector mask.
	function automatic msr_axis_e nth_axis(input logic [2:0] mask, input logic [2:0] n);
		logic [2:0] cnt;
		cnt = 3'h0;
		nth_axis = AXIS_NONE;
		if (mask[2]) begin
			if (cnt == n) nth_axis = AXIS_Z;
			cnt = cnt + 3'h1;
		end
		if (mask[1]) begin
			if (cnt == n) nth_axis = AXIS_Y;
			cnt = cnt + 3'h1;
		end
		if (mask[0] && cnt == n) begin
			nth_axis = AXIS_X;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// State.

	logic [7:0] addr_q, addr_d;
	logic [2:0] idx_q, idx_d;
	logic over_q, over_d;
	logic ready_q, ready_d;
	logic skip_q, skip_d;
	logic [5:0] sw_q, sw_d;
	logic planar_q, planar_d;
	logic conv_q, conv_d;
	logic signed [15:0] fx_q, fx_d, fy_q, fy_d, fz_q, fz_d;
	logic [7:0] rd_data_q, rd_data_d;
	logic rd_valid_q, rd_valid_d;

	logic signed [15:0] px, py;
	logic planar_clip;
	logic new_result;
	logic [15:0] status;
	logic [7:0] byte_out;
	logic axis_done;
	logic set_access;
	msr_axis_e axis;
	logic half_low;

	// Wide range clips the planar axes; Z always keeps the full 16-bit range.
	always_comb begin
		px = range_select ? clamp_wide(meas.x) : meas.x;
		py = range_select ? clamp_wide(meas.y) : meas.y;
		planar_clip = range_select && (px != meas.x || py != meas.y);
	end

	assign new_result = meas.done && is_active(op_mode);
	assign status = {COND_FIXED_ONES, skip_q, conv_q, planar_q, sw_q, ready_q};
	assign set_access = acc_start && acc_addr >= ADDR_SET_FIRST && acc_addr <= ADDR_SET_LAST;

	////////////////////////////////////////////////////////////////////////////////
	// Byte sequencer: auto-increments within one burst; bytes past the map read zero.

	always_comb begin
		logic [2:0] slot;
		slot = 3'h0;
		byte_out = 8'h00;
		axis_done = 1'b0;
		axis = AXIS_NONE;
		half_low = 1'b0;
		if (addr_q >= ADDR_DATA_FIRST && addr_q <= ADDR_DATA_LAST && idx_q >= IDX_FIRST_AXIS) begin
			if (addr_q >= ADDR_HIGH_ONLY) begin
				slot = idx_q - IDX_FIRST_AXIS;
				half_low = 1'b0;
			end else begin
				slot = 3'((idx_q - IDX_FIRST_AXIS) >> 1);
				half_low = idx_q[0];
			end
			axis = nth_axis(addr_q[2:0], slot);
		end
		if (!over_q) begin
			if (addr_q == ADDR_IDENT) begin
				unique case (idx_q[1:0])
					2'h0: byte_out = COMPANY_CODE;
					2'h1: byte_out = DEVICE_CODE;
					2'h2: byte_out = RESERVED_WORD[15:8];
					2'h3: byte_out = RESERVED_WORD[7:0];
				endcase
				if (idx_q > 3'h3) byte_out = 8'h00;
			end else if (addr_q >= ADDR_DATA_FIRST && addr_q <= ADDR_DATA_LAST) begin
				if (idx_q == 3'h0) byte_out = status[15:8];
				else if (idx_q == 3'h1) byte_out = status[7:0];
				else begin
					unique case (axis)
						AXIS_X: byte_out = half_low ? fx_q[7:0] : fx_q[15:8];
						AXIS_Y: byte_out = half_low ? fy_q[7:0] : fy_q[15:8];
						AXIS_Z: byte_out = half_low ? fz_q[7:0] : fz_q[15:8];
						AXIS_NONE: byte_out = 8'h00;
					endcase
					// The last listed byte of an axis completes it; high-only maps end on the high byte.
					axis_done = (axis != AXIS_NONE) && (half_low || addr_q >= ADDR_HIGH_ONLY);
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	always_comb begin
		addr_d = addr_q;
		idx_d = idx_q;
		over_d = over_q;
		rd_valid_d = 1'b0;
		rd_data_d = rd_data_q;
		ready_d = ready_q;
		skip_d = skip_q;
		sw_d = sw_q;
		planar_d = planar_q;
		conv_d = conv_q;
		fx_d = fx_q;
		fy_d = fy_q;
		fz_d = fz_q;
		if (acc_start) begin
			addr_d = acc_addr;
			idx_d = 3'h0;
			over_d = 1'b0;
		end else if (acc_rd) begin
			rd_valid_d = 1'b1;
			rd_data_d = byte_out;
			if (idx_q == IDX_LAST) over_d = 1'b1;
			else idx_d = idx_q + 3'h1;
		end
		// Clears first so that a result landing in the same cycle wins.
		if ((acc_rd && !acc_start && axis_done) || set_access) begin
			ready_d = 1'b0;
		end
		if (new_result) begin
			ready_d = 1'b1;
			// In a continuous mode, a result still unread when the next one lands has been skipped.
			skip_d = is_cont(op_mode) && ready_q;
			fx_d = px;
			fy_d = py;
			fz_d = meas.z;
			sw_d[0] = sw_next(sw_q[0], px, thr[0].op1, thr[0].rp1);
			sw_d[1] = sw_next(sw_q[1], px, thr[0].op2, thr[0].rp2);
			sw_d[2] = sw_next(sw_q[2], py, thr[1].op1, thr[1].rp1);
			sw_d[3] = sw_next(sw_q[3], py, thr[1].op2, thr[1].rp2);
			sw_d[4] = sw_next(sw_q[4], meas.z, thr[2].op1, thr[2].rp1);
			sw_d[5] = sw_next(sw_q[5], meas.z, thr[2].op2, thr[2].rp2);
			planar_d = meas.xy_sat || planar_clip;
			conv_d = meas.adc_ovf;
		end
	end

	// Every register returns to its reset value while the reset pin is low.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			addr_q <= ADDR_IDENT;
			idx_q <= 3'h0;
			over_q <= 1'b0;
			ready_q <= COND_RESET[COND_READY];
			skip_q <= COND_RESET[COND_SKIP];
			sw_q <= COND_RESET[COND_SW_LSB +: 6];
			planar_q <= COND_RESET[COND_PLANAR];
			conv_q <= COND_RESET[COND_CONV];
			fx_q <= 16'sh0000;
			fy_q <= 16'sh0000;
			fz_q <= 16'sh0000;
			rd_data_q <= 8'h00;
			rd_valid_q <= 1'b0;
		end else begin
			addr_q <= addr_d;
			idx_q <= idx_d;
			over_q <= over_d;
			ready_q <= ready_d;
			skip_q <= skip_d;
			sw_q <= sw_d;
			planar_q <= planar_d;
			conv_q <= conv_d;
			fx_q <= fx_d;
			fy_q <= fy_d;
			fz_q <= fz_d;
			rd_data_q <= rd_data_d;
			rd_valid_q <= rd_valid_d;
		end
	end

	assign rd_data = rd_data_q;
	assign rd_valid = rd_valid_q;
	assign data_ready_flag = ready_q;

	////////////////////////////////////////////////////////////////////////////////
	// Assertions.

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence id_burst_s;
		acc_start && acc_addr == ADDR_IDENT ##1 !acc_start && acc_rd;
	endsequence

	sequence setting_touch_s;
		set_access && !new_result;
	endsequence

	// The read that hands out the last byte of an axis, with no result landing beside it.
	sequence axis_finish_s;
		acc_rd && !acc_start && axis_done && !new_result;
	endsequence

	// The read of the upper status byte in a sample burst.
	sequence status_high_read_s;
		acc_rd && !acc_start && !over_q && idx_q == 3'h0 && addr_q >= ADDR_DATA_FIRST && addr_q <= ADDR_DATA_LAST;
	endsequence

	ready_set_a: assert property (new_result |=> ready_q && status[COND_READY])
		else $error("data ready not set");
	ready_clear_a: assert property (setting_touch_s |=> !ready_q)
		else $error("data ready kept after setting access");
	axis_clear_a: assert property (axis_finish_s |=> !ready_q)
		else $error("data ready kept after axis read");
	overrun_set_a: assert property (new_result && is_cont(op_mode) && ready_q |=> skip_q)
		else $error("skip missed");
	overrun_clear_a: assert property (new_result && !ready_q |=> !skip_q)
		else $error("overrun not cleared");
	switch_one_a: assert property (new_result && px >= thr[0].op1 |=> sw_q[0])
		else $error("x switch one wrong");
	switch_two_a: assert property (new_result && meas.z <= thr[2].rp2 && meas.z < thr[2].op2 |=> !sw_q[5])
		else $error("z switch two wrong");
	planar_flag_a: assert property (new_result && meas.xy_sat |=> planar_q)
		else $error("planar overflow not flagged");
	adc_flag_a: assert property (new_result |=> conv_q == $past(meas.adc_ovf))
		else $error("converter flag wrong");
	full_range_a: assert property (new_result && !range_select |=> fx_q == $past(meas.x) && fy_q == $past(meas.y))
		else $error("planar sample altered in high sensitivity");
	wide_clip_a: assert property (new_result && range_select |=> fx_q <= WIDE_LIMIT && fx_q >= -WIDE_LIMIT)
		else $error("planar sample beyond wide limit");
	z_full_a: assert property (new_result |=> fz_q == $past(meas.z))
		else $error("z sample altered");
	read_answer_a: assert property (acc_rd && !acc_start |=> rd_valid)
		else $error("byte read not answered");
	fixed_ones_a: assert property (status_high_read_s |=> rd_data[7:2] == COND_FIXED_ONES)
		else $error("fixed status bits lost");
	ident_read_a: assert property (id_burst_s |=> rd_valid && rd_data == COMPANY_CODE)
		else $error("identity byte wrong");

endmodule

`default_nettype wire

//--- design/msr_pkg.sv
// Package of constants and carrier types for the magnetometer status and data register bank.
package msr_pkg;

	// Register byte addresses.
	localparam logic [7:0] ADDR_IDENT = 8'h00;
	localparam logic [7:0] ADDR_DATA_FIRST = 8'h10;
	localparam logic [7:0] ADDR_HIGH_ONLY = 8'h18;
	localparam logic [7:0] ADDR_DATA_LAST = 8'h1f;
	localparam logic [7:0] ADDR_SET_FIRST = 8'h20;
	localparam logic [7:0] ADDR_SET_LAST = 8'h27;

	// Burst geometry: status takes two byte slots before the axis bytes.
	localparam logic [2:0] IDX_FIRST_AXIS = 3'h2;
	localparam logic [2:0] IDX_LAST = 3'h7;

	// Status word layout and reset value.
	localparam int COND_READY = 0;
	localparam int COND_SW_LSB = 1;
	localparam int COND_PLANAR = 7;
	localparam int COND_CONV = 8;
	localparam int COND_SKIP = 9;
	localparam logic [5:0] COND_FIXED_ONES = 6'h3f;
	localparam logic [15:0] COND_RESET = 16'hfc00;

	// Wide-range limit of the planar axes (11264).
	localparam logic signed [15:0] WIDE_LIMIT = 16'sh2c00;

	// Operation mode codes.
	localparam logic [3:0] MODE_POWER_DOWN = 4'h0;
	localparam logic [3:0] MODE_SINGLE = 4'h1;

	// Axis selector codes used by the byte sequencer.
	typedef enum logic [1:0] {
		AXIS_NONE = 2'b00,
		AXIS_X = 2'b01,
		AXIS_Y = 2'b10,
		AXIS_Z = 2'b11
	} msr_axis_e;

	// Switch thresholds of one axis: operating and returning points of both switches.
	typedef struct packed {
		logic signed [15:0] op1;
		logic signed [15:0] rp1;
		logic signed [15:0] op2;
		logic signed [15:0] rp2;
	} msr_thr_s;

	// One finished conversion from the measurement engine.
	typedef struct packed {
		logic done;
		logic signed [15:0] x;
		logic signed [15:0] y;
		logic signed [15:0] z;
		logic xy_sat;
		logic adc_ovf;
	} msr_meas_s;

endpackage

//--- verification/msr_host.sv
// Host controller model that reads the register bank byte by byte.
`timescale 1ns/10ps
`default_nettype none

module msr_host (
	// Clock
	input wire logic clk,
	// Read port of the bank
	output var logic acc_start,
	output var logic [7:0] acc_addr,
	output var logic acc_rd,
	input wire logic [7:0] rd_data,
	input wire logic rd_valid
);
	logic [7:0] got [8];

	initial begin
		acc_start = 1'b0;
		acc_addr = 8'h00;
		acc_rd = 1'b0;
	end

	////////////////////////////////////////
	// Callers never pass the factory test addresses
	task automatic read(input logic [7:0] a, input int n);
		acc_start = 1'b1;
		acc_addr = a;
		@(negedge clk);
		acc_start = 1'b0;
		// The address only counts with acc_start, so a stale copy would hide a sampling slip.
		acc_addr = ~a;
		for (int i = 0; i < n; i++) begin
			acc_rd = 1'b1;
			@(negedge clk);
			got[i] = rd_valid ? rd_data : 8'hxx;
		end
		acc_rd = 1'b0;
	endtask
endmodule

`default_nettype wire

//--- verification/tb.sv
// Self-checking testbench of the status and sample register bank.
`timescale 1ns/10ps
`default_nettype none

module tb;
	import msr_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic acc_start, acc_rd, rd_valid, data_ready_flag;
	logic range_select = 1'b0;
	logic [7:0] acc_addr, rd_data;
	logic [3:0] op_mode = 4'h2;
	msr_thr_s [2:0] thr;
	msr_meas_s meas = '0;
	int n_fail = 0;
	int total_checks = 0;
	int cyc = 0;
	logic [3:0] modes [10] = '{4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'ha, 4'hc, 4'he, 4'h0, 4'h3};

	always #25 clk = ~clk;

	msr_regs uut (.clk(clk), .resetn(resetn), .acc_start(acc_start), .acc_addr(acc_addr), .acc_rd(acc_rd),
		.rd_data(rd_data), .rd_valid(rd_valid), .op_mode(op_mode), .range_select(range_select), .thr(thr),
		.meas(meas), .data_ready_flag(data_ready_flag));
	msr_host host (.clk(clk), .acc_start(acc_start), .acc_addr(acc_addr), .acc_rd(acc_rd),
		.rd_data(rd_data), .rd_valid(rd_valid));

	////////////////////////////////////////
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected byte at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_flag(input logic exp);
		total_checks++;
		if (data_ready_flag !== exp) begin
			n_fail++;
			$display("unexpected flag at %0t: got %h expected %h", $time, data_ready_flag, exp);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input int n, input logic [63:0] e);
		host.read(a, n);
		for (int i = 0; i < n; i++) chk_byte(host.got[i], e[63-8*i -: 8]);
	endtask

	// One idle cycle after each result keeps done from being lowered and raised in one step.
	task automatic measure(input logic [15:0] x, y, z, input logic s, o);
		meas = {1'b1, x, y, z, s, o};
		@(negedge clk);
		meas.done = 1'b0;
		@(negedge clk);
	endtask

	task automatic end_test(input string s);
		$display("test %s done", s);
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// The whole sequence needs about 115 cycles.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_fail++;
			print_verdict();
		end
	end

	////////////////////////////////////////
	initial begin
		for (int i = 0; i < 3; i++) thr[i] = {16'h0064, 16'hff9c, 16'h03e8, 16'h01f4};
		repeat (12) @(negedge clk);
		resetn = 1'b1;
		chk_flag(1'b0);
		rd_chk(8'h10, 3, 64'hfc00_0000_0000_0000);
		rd_chk(8'h00, 4, 64'ha55a_0000_0000_0000);
		rd_chk(8'h08, 1, 64'h0);
		end_test("reset");
		measure(16'h1234, 16'hfffe, 16'h7fff, 1'b0, 1'b0);
		chk_flag(1'b1);
		rd_chk(8'h17, 8, 64'hfc67_7fff_fffe_1234);
		chk_flag(1'b0);
		end_test("burst");
		measure(16'hff38, 16'hff38, 16'hff38, 1'b0, 1'b0);
		measure(16'hff38, 16'hff38, 16'hff38, 1'b0, 1'b0);
		rd_chk(8'h10, 2, 64'hfe01_0000_0000_0000);
		rd_chk(8'h12, 4, 64'hfe01_ff38_0000_0000);
		measure(16'hff38, 16'hff38, 16'hff38, 1'b0, 1'b0);
		rd_chk(8'h10, 2, 64'hfc01_0000_0000_0000);
		end_test("overrun");
		host.read(8'h20, 0);
		chk_flag(1'b0);
		range_select = 1'b1;
		measure(16'h3000, 16'h8000, 16'h8000, 1'b0, 1'b1);
		rd_chk(8'h17, 8, 64'hfd87_8000_d400_2c00);
		// A fresh result, so that the high-only burst has a ready flag of its own to clear.
		measure(16'h3000, 16'h8000, 16'h8000, 1'b0, 1'b1);
		rd_chk(8'h1b, 4, 64'hfd87_d42c_0000_0000);
		chk_flag(1'b0);
		range_select = 1'b0;
		end_test("wide");
		for (int i = 0; i < 10; i++) begin
			op_mode = modes[i];
			measure(16'hff38, 16'hff38, 16'hff38, 1'b0, 1'b0);
			chk_flag(i < 8);
			host.read(8'h20, 0);
		end
		op_mode = 4'h2;
		measure(16'hff38, 16'hff38, 16'hff38, 1'b1, 1'b0);
		rd_chk(8'h10, 2, 64'hfc81_0000_0000_0000);
		end_test("modes");
		// A reset in mid-run must drop every status bit and sample gathered so far.
		chk_flag(1'b1);
		resetn = 1'b0;
		@(negedge clk);
		resetn = 1'b1;
		chk_flag(1'b0);
		rd_chk(8'h17, 8, 64'hfc00_0000_0000_0000);
		end_test("mid reset");
		print_verdict();
	end
endmodule

`default_nettype wire
